/* src/btd_pkg.sv */
// Constants and types shared by the bus trace debug register block
package btd_pkg;
  // ***************************************************
  // Register offsets in the byte-wide register window
  // ***************************************************
  localparam logic [3:0] OFS_CAH  = 4'h0;
  localparam logic [3:0] OFS_CAL  = 4'h1;
  localparam logic [3:0] OFS_CBH  = 4'h2;
  localparam logic [3:0] OFS_CBL  = 4'h3;
  localparam logic [3:0] OFS_FH   = 4'h4;
  localparam logic [3:0] OFS_FL   = 4'h5;
  localparam logic [3:0] OFS_CTRL = 4'h6;
  localparam logic [3:0] OFS_TRIG = 4'h7;
  localparam logic [3:0] OFS_STAT = 4'h8;
  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int unsigned CTRL_EN    = 7;
  localparam int unsigned CTRL_ARM   = 6;
  localparam int unsigned CTRL_TAG   = 5;
  localparam int unsigned CTRL_BRK   = 4;
  localparam int unsigned CTRL_DIR_A = 3;
  localparam int unsigned CTRL_CHK_A = 2;
  localparam int unsigned CTRL_DIR_B = 1;
  localparam int unsigned CTRL_CHK_B = 0;
  localparam int unsigned TRIG_TQS   = 7;
  localparam int unsigned TRIG_BEGIN = 6;
  localparam int unsigned STAT_AF    = 7;
  localparam int unsigned STAT_BF    = 6;
  localparam int unsigned STAT_RUN   = 5;
  // ***************************************************
  // Reset values and sizes
  // ***************************************************
  localparam logic [7:0] CMP_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h00;
  localparam int unsigned BUF_W     = 16;
  localparam int unsigned BUF_DEPTH = 8;
  // Trigger modes
  typedef enum logic [3:0] {
    MODE_A       = 4'h0,
    MODE_A_OR_B  = 4'h1,
    MODE_A_THEN_B = 4'h2,
    MODE_EV_B    = 4'h3,
    MODE_A_EV_B  = 4'h4
  } btd_mode_t;
  // Run sequencing
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_PRE  = 2'b01,
    RUN_POST = 2'b10
  } btd_run_t;
endpackage

/* src/btd_fifo.sv */
// Trace buffer FIFO with valid/ready on both sides
`timescale 1ns/1ps
module btd_fifo #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0]   lvl_q;
  logic          push;
  logic          pop;

  // A full buffer still accepts a word when one leaves in the same cycle
  assign in_ready  = (lvl_q != (PW+1)'(DEPTH)) | out_ready;
  assign out_valid = (lvl_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign level     = lvl_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage; pointers wrap naturally, so DEPTH must be a power of two
  // Cleared at reset so that reading an empty buffer is never unknown
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_q <= '{default: '0};
    end else if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!resetn || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      lvl_q    <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
      lvl_q <= lvl_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  chk_fifo_bound: assert property (
    @(posedge clk) disable iff (!resetn)
    lvl_q <= (PW+1)'(DEPTH))
    else $error("buffer holds more words than its depth");
endmodule // btd_fifo

/* src/btd_cmp.sv */
// One 16-bit address comparator with its two byte registers
`timescale 1ns/1ps
module btd_cmp (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic [7:0]  wdata,
  input  wire logic        armed,
  input  wire logic        dir_check,
  input  wire logic        dir_value,
  input  wire logic        bus_valid,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_addr,
  output logic [15:0]      value,
  output logic             match_q
);
  import btd_pkg::*;
  logic dir_ok;

  // Compare value; locked while a run is armed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      value <= {CMP_RST, CMP_RST};
    end else if (!armed) begin
      if (wr_hi) value[15:8] <= wdata;
      if (wr_lo) value[7:0]  <= wdata;
    end
  end

  // Direction qualification: read when dir_value is one
  assign dir_ok = !dir_check || (bus_rd == dir_value);

  // Registered match towards the trigger logic
  always_ff @(posedge clk) begin
    if (!resetn) begin
      match_q <= 1'b0;
    end else begin
      match_q <= armed & bus_valid & dir_ok & (bus_addr == value);
    end
  end

  chk_cmp_wr_lock: assert property (
    @(posedge clk) disable iff (!resetn)
    (armed && (wr_hi || wr_lo)) |=> $stable(value))
    else $error("comparator changed while armed");
  chk_cmp_dir: assert property (
    @(posedge clk) disable iff (!resetn)
    match_q |-> $past(dir_ok) && $past(armed))
    else $error("comparator matched on wrong direction");
endmodule // btd_cmp

/* src/btd_top.sv */
// Bus trace debug registers: comparators, trace buffer port, control
// Operation
// - nine bytes: two split comparators, buffer port, three control bytes
// - comparator bytes reset to zero, readable, writable only when unarmed
// - high byte holds upper eight bits, low byte lower eight bits
// - buffer high byte is read-only, reads zero in event-only modes
// - high byte read keeps position, low byte read advances buffer
// - event-only modes store 8-bit data; repeated low reads suffice
// - low byte reads never advance the buffer while armed
// - outside readout, unarmed low byte read stores last fetched opcode address
// - outside readout, unarmed reads return the address stored eight reads earlier
// - control always accessible; enable cannot be set while secure
// - arm bit starts run, self-clears at end, zero stops run
// - bit 5 picks immediate or execution-qualified break kind
// - bit 4 lets triggers or a full buffer request a break
// - qualification select never shifts break timing
// - bits 2 and 3 qualify comparator A by bus direction
// - bits 0 and 1 qualify comparator B by bus direction
// - run ends on full buffer (begin) or trigger (end trace)
// - eight words; count cleared at start, kept through readout
`timescale 1ns/1ps
module btd_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata_q,
  input  wire logic        secure_mode,
  input  wire logic        cpu_valid,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_fetch,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_data,
  output logic             match_a_q,
  output logic             match_b_q,
  output logic             break_req_q,
  output logic             break_tag_q
);
  import btd_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ***************************************************
  // Declarations
  // ***************************************************
  logic [7:0]      ctrl_q;
  logic [7:0]      trig_q;
  btd_run_t        run_q;
  logic            a_seen_q;
  logic            a_flag_q;
  logic            b_flag_q;
  logic [3:0]      cnt_q;
  logic [3:0]      drain_q;
  logic [15:0]     last_fetch_q;
  logic [15:0]     addr_s1_q;
  logic [7:0]      data_s1_q;
  logic            fetch_s1_q;
  logic [15:0]     cmp_a;
  logic [15:0]     cmp_b;
  logic            armed;
  logic            ev_mode;
  logic            begin_trc;
  logic            wr_ctrl;
  logic            run_start;
  logic            run_end;
  logic            trig_ev;
  logic            store;
  logic            rd_lo;
  logic            rd_hi;
  logic            prof_rd;
  logic            drain_rd;
  logic            buf_in_valid;
  logic            buf_in_ready;
  logic [15:0]     buf_in_data;
  logic            buf_out_valid;
  logic            buf_out_ready;
  logic [15:0]     buf_out_data;
  logic [3:0]      buf_level;
  logic            buf_full;

  // Strobe decode shared by the write strobes and buffer read strobes; strobe and address are
  // arguments so that continuous uses follow them when they change
  function automatic logic hit_at(input logic       strobe,
                                  input logic [3:0] a,
                                  input logic [3:0] ofs);
    return strobe && (a == ofs);
  endfunction

  assign armed     = ctrl_q[CTRL_ARM];
  assign ev_mode   = (trig_q[3:0] == MODE_EV_B) || (trig_q[3:0] == MODE_A_EV_B);
  assign begin_trc = trig_q[TRIG_BEGIN] | ev_mode;
  assign wr_ctrl   = hit_at(reg_wr, reg_addr, OFS_CTRL);
  assign rd_lo     = hit_at(reg_rd, reg_addr, OFS_FL);
  assign rd_hi     = hit_at(reg_rd, reg_addr, OFS_FH);
  assign buf_full  = (buf_level == 4'(BUF_DEPTH));
  // A fresh run starts only on an arm write that actually sets the bit
  assign run_start = wr_ctrl && reg_wdata[CTRL_ARM] && !armed
                     && (reg_wdata[CTRL_EN] && !secure_mode);

  // ***************************************************
  // Comparators
  // ***************************************************
  btd_cmp u_cmp_a (
    .clk       (clk),
    .resetn    (resetn),
    .wr_hi     (hit_at(reg_wr, reg_addr, OFS_CAH)),
    .wr_lo     (hit_at(reg_wr, reg_addr, OFS_CAL)),
    .wdata     (reg_wdata),
    .armed     (armed),
    .dir_check (ctrl_q[CTRL_CHK_A]),
    .dir_value (ctrl_q[CTRL_DIR_A]),
    .bus_valid (cpu_valid),
    .bus_rd    (cpu_rd),
    .bus_addr  (cpu_addr),
    .value     (cmp_a),
    .match_q   (match_a_q)
  );

  btd_cmp u_cmp_b (
    .clk       (clk),
    .resetn    (resetn),
    .wr_hi     (hit_at(reg_wr, reg_addr, OFS_CBH)),
    .wr_lo     (hit_at(reg_wr, reg_addr, OFS_CBL)),
    .wdata     (reg_wdata),
    .armed     (armed),
    .dir_check (ctrl_q[CTRL_CHK_B]),
    .dir_value (ctrl_q[CTRL_DIR_B]),
    .bus_valid (cpu_valid),
    .bus_rd    (cpu_rd),
    .bus_addr  (cpu_addr),
    .value     (cmp_b),
    .match_q   (match_b_q)
  );

  // ***************************************************
  // Control and trigger registers
  // ***************************************************
  // Software arming wins over a run ending in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata;
      ctrl_q[CTRL_EN]  <= reg_wdata[CTRL_EN] & ~secure_mode;
      ctrl_q[CTRL_ARM] <= reg_wdata[CTRL_ARM] & reg_wdata[CTRL_EN]
                          & ~secure_mode;
    end else if (run_end) begin
      ctrl_q[CTRL_ARM] <= 1'b0;
    end
  end

  // Trigger setup follows the comparators' lock while armed
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trig_q <= TRIG_RST;
    end else if (hit_at(reg_wr, reg_addr, OFS_TRIG) && !armed) begin
      trig_q <= {reg_wdata[7:6], 2'b00, reg_wdata[3:0]};
    end
  end

  // ***************************************************
  // Bus pipeline aligned with the comparator matches
  // ***************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_s1_q    <= '0;
      data_s1_q    <= '0;
      fetch_s1_q   <= 1'b0;
      last_fetch_q <= '0;
    end else begin
      addr_s1_q  <= cpu_addr;
      data_s1_q  <= cpu_data;
      fetch_s1_q <= cpu_valid & cpu_fetch;
      if (cpu_valid && cpu_fetch) last_fetch_q <= cpu_addr;
    end
  end

  // ***************************************************
  // Trigger and run sequencing
  // ***************************************************
  // Modes without a trigger here never end an end trace on their own
  always_comb begin
    case (trig_q[3:0])
      MODE_A:        trig_ev = match_a_q;
      MODE_A_OR_B:   trig_ev = match_a_q | match_b_q;
      MODE_A_THEN_B: trig_ev = a_seen_q & match_b_q;
      default:       trig_ev = 1'b0;
    endcase
  end

  // Storage: fetch addresses, or data bytes on B in event modes
  always_comb begin
    store = 1'b0;
    case (run_q)
      RUN_PRE:  store = fetch_s1_q & ~begin_trc;
      RUN_POST: begin
        if (ev_mode) begin
          store = match_b_q
                  & ((trig_q[3:0] == MODE_EV_B) | a_seen_q);
        end else begin
          store = fetch_s1_q;
        end
      end
      default:  store = 1'b0;
    endcase
  end

  // Run end: buffer full in begin trace, trigger in end trace
  assign run_end = armed && (((run_q == RUN_POST) && buf_full)
                   || ((run_q == RUN_PRE) && !begin_trc && trig_ev));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_q <= RUN_IDLE;
    end else if (run_start) begin
      run_q <= ev_mode ? RUN_POST : RUN_PRE;
    end else if (!armed || run_end) begin
      run_q <= RUN_IDLE;
    end else begin
      case (run_q)
        RUN_PRE:  if (begin_trc && trig_ev) run_q <= RUN_POST;
        default:  run_q <= run_q;
      endcase
    end
  end

  // Match history; cleared when a run starts
  always_ff @(posedge clk) begin
    if (!resetn || run_start) begin
      a_seen_q <= 1'b0;
      a_flag_q <= 1'b0;
      b_flag_q <= 1'b0;
    end else begin
      if (match_a_q) a_seen_q <= 1'b1;
      if (match_a_q) a_flag_q <= 1'b1;
      if (match_b_q) b_flag_q <= 1'b1;
    end
  end

  // Valid count: frozen at run end, not touched by readout
  always_ff @(posedge clk) begin
    if (!resetn || run_start) begin
      cnt_q <= '0;
    end else if (run_end) begin
      cnt_q <= buf_level;
    end
  end

  // ***************************************************
  // Trace buffer and its read port
  // ***************************************************
  // After a run, low reads walk the stored words; then profiling resumes
  assign drain_rd = rd_lo && !armed && (drain_q != '0);
  assign prof_rd  = rd_lo && !armed && (drain_q == '0);

  always_ff @(posedge clk) begin
    if (!resetn || run_start) begin
      drain_q <= '0;
    end else if (run_end) begin
      drain_q <= buf_level;
    end else if (drain_rd) begin
      drain_q <= drain_q - 4'h1;
    end
  end

  // Profiling pops only once full, giving an eight-read delay
  assign buf_in_valid  = store | prof_rd;
  assign buf_in_data   = prof_rd ? last_fetch_q
                       : (ev_mode ? {8'h00, data_s1_q} : addr_s1_q);
  // End trace overwrites the oldest word; armed reads never pop
  assign buf_out_ready = ((run_q == RUN_PRE) && store && buf_full)
                         || drain_rd || (prof_rd && buf_full);

  btd_fifo #(
    .W     (BUF_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (run_start),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data),
    .level     (buf_level)
  );

  // ***************************************************
  // Break requests
  // ***************************************************
  // Issued at run end whatever the qualification select says
  always_ff @(posedge clk) begin
    if (!resetn) begin
      break_req_q <= 1'b0;
      break_tag_q <= 1'b0;
    end else begin
      break_req_q <= run_end & ctrl_q[CTRL_BRK];
      break_tag_q <= ctrl_q[CTRL_BRK] & ctrl_q[CTRL_TAG];
    end
  end

  // ***************************************************
  // Register read port
  // ***************************************************
  // Read data is registered; unmapped offsets read as zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == OFS_CAH)       reg_rdata_q <= cmp_a[15:8];
      else if (reg_addr == OFS_CAL)  reg_rdata_q <= cmp_a[7:0];
      else if (reg_addr == OFS_CBH)  reg_rdata_q <= cmp_b[15:8];
      else if (reg_addr == OFS_CBL)  reg_rdata_q <= cmp_b[7:0];
      else if (reg_addr == OFS_FH)
        reg_rdata_q <= ev_mode ? 8'h00 : buf_out_data[15:8];
      else if (reg_addr == OFS_FL)   reg_rdata_q <= buf_out_data[7:0];
      else if (reg_addr == OFS_CTRL) reg_rdata_q <= ctrl_q;
      else if (reg_addr == OFS_TRIG) reg_rdata_q <= trig_q;
      else if (reg_addr == OFS_STAT)
        reg_rdata_q <= {a_flag_q, b_flag_q, armed, 1'b0, cnt_q};
      else                           reg_rdata_q <= 8'h00;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  chk_fh_event_zero: assert property (
    (rd_hi && ev_mode) |=> reg_rdata_q == 8'h00)
    else $error("high byte not zero in event mode");
  chk_hi_no_advance: assert property (
    (rd_hi && !store) |=> $stable(buf_level) && $stable(buf_out_data))
    else $error("high byte read moved the buffer");
  chk_armed_no_pop: assert property (
    (rd_lo && armed && !store) |=> $stable(buf_out_data))
    else $error("armed low read advanced the buffer");
  chk_en_secure: assert property (
    (secure_mode && wr_ctrl) |=> !ctrl_q[CTRL_EN])
    else $error("enable set while secure");
  chk_run_end_clear: assert property (
    (run_end && !wr_ctrl) |=> !armed && run_q == RUN_IDLE)
    else $error("run end left module armed");
  chk_cnt_start: assert property (
    run_start |=> cnt_q == 4'h0 && buf_level == 4'h0 && armed)
    else $error("run start did not clear count");
  chk_break_timing: assert property (
    (run_end && ctrl_q[CTRL_BRK]) |=> break_req_q ##1 !break_req_q)
    else $error("break request not a single pulse at run end");
  chk_prof_fill: assert property (
    (prof_rd && !buf_full) |=> buf_level == $past(buf_level) + 4'h1)
    else $error("profiling read did not store an address");
  chk_cmp_lock_arm: assert property (
    (armed && hit_at(reg_wr, reg_addr, OFS_CAL)) |=> $stable(cmp_a))
    else $error("comparator A written while armed");
  chk_prof_accept: assert property (
    prof_rd |-> buf_in_ready)
    else $error("profiling read found the buffer closed");
  chk_drain_stored: assert property (
    drain_rd |-> buf_out_valid)
    else $error("readout popped an empty buffer");

  cov_end_trace: cover property (run_end && !begin_trc);
  cov_begin_full: cover property (run_end && begin_trc && buf_full);
  cov_prof_wrap: cover property (prof_rd && buf_full);
endmodule // btd_top

/* tb/btd_cpu_model.sv */
// CPU bus model that issues single bus cycles on request
`timescale 1ns/1ps
module btd_cpu_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        req,
  input  wire logic        b_rd,
  input  wire logic        b_fetch,
  input  wire logic [15:0] b_addr,
  input  wire logic [7:0]  b_data,
  output logic             cpu_valid,
  output logic             cpu_rd,
  output logic             cpu_fetch,
  output logic [15:0]      cpu_addr,
  output logic [7:0]       cpu_data
);
  // One cycle per request; an idle bus keeps toggling address and data
  // so a design that samples outside valid cycles sees garbage.
  // The bus is held low in reset so nothing is unknown at its release.
  always @(posedge clk) begin
    if (!resetn) begin
      {cpu_valid, cpu_rd, cpu_fetch, cpu_addr, cpu_data} <= '0;
    end else begin
      cpu_valid <= req;
      cpu_fetch <= req & b_fetch;
      if (req) begin
        cpu_rd   <= b_rd;
        cpu_addr <= b_addr;
        cpu_data <= b_data;
      end else begin
        cpu_addr <= ~cpu_addr;
        cpu_data <= ~cpu_data;
      end
    end
  end
endmodule // btd_cpu_model

/* tb/tb.sv */
// Self-checking bench for the bus trace debug register block
`timescale 1ns/1ps
module tb;
  import btd_pkg::*;
  logic        clk, resetn, reg_wr, reg_rd, secure_mode;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q, v, c, b_data, cpu_data;
  logic        req, b_rd, b_fetch, cpu_valid, cpu_rd, cpu_fetch;
  logic [15:0] b_addr, cpu_addr, w, aval, bval;
  logic        match_a_q, match_b_q, break_req_q, break_tag_q;
  logic        sel_b, seen_m, seen_brk, seen_tag, clr_seen;
  logic [15:0] hist [12];
  logic [7:0]  ev [8];
  int          miscompares, checked;

  btd_top i_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .secure_mode, .cpu_valid, .cpu_rd, .cpu_fetch,
    .cpu_addr, .cpu_data, .match_a_q, .match_b_q, .break_req_q,
    .break_tag_q);
  btd_cpu_model i_cpu (.clk, .resetn, .req, .b_rd, .b_fetch, .b_addr, .b_data,
    .cpu_valid, .cpu_rd, .cpu_fetch, .cpu_addr, .cpu_data);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Remember match and break pulses, they stand for one cycle only
  // Only this process drives the seen flags; the sequence asks for a clear
  always @(posedge clk) begin
    if (clr_seen) begin
      {seen_m, seen_brk, seen_tag} <= 3'b000;
    end else begin
      if (sel_b ? match_b_q : match_a_q) seen_m <= 1'b1;
      if (break_req_q) begin
        seen_brk <= 1'b1;
        seen_tag <= break_tag_q;
      end
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is registered: it lands at the edge that takes the read
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  // One CPU bus cycle, then time for match and break to show
  task automatic bus(input logic r, input logic f, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    req     <= 1'b1;
    b_rd    <= r;
    b_fetch <= f;
    b_addr  <= a;
    b_data  <= d;
    @(posedge clk);
    req <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  // The seen process takes the clear at the second edge
  task automatic clear_seen();
    @(posedge clk);
    clr_seen <= 1'b1;
    @(posedge clk);
    clr_seen <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog far beyond the expected run length
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end

  // Main sequence
  initial begin
    {resetn, reg_wr, reg_rd, secure_mode, req, b_rd, b_fetch} = '0;
    {sel_b, clr_seen} = 2'b01;
    {reg_addr, reg_wdata, b_addr, b_data} = '0;
    miscompares = 0;
    checked = 0;
    void'($urandom(4810));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    clr_seen <= 1'b0;
    // Reset values, and an unmapped offset that reads zero
    for (int i = 0; i < 10; i++) begin
      if (i == 4 || i == 5) continue;
      rd(4'(i), v);
      chk({8'h0, v}, 16'h0);
    end
    // Enable cannot be set while the device is secure
    @(posedge clk) secure_mode <= 1'b1;
    wr(OFS_CTRL, 8'h80);
    rd(OFS_CTRL, v);
    chk({8'h0, v}, 16'h0);
    @(posedge clk) secure_mode <= 1'b0;
    wr(OFS_CTRL, 8'h80);
    rd(OFS_CTRL, v);
    chk({8'h0, v}, 16'h80);
    // Profiling: each low read records the last fetch address
    for (int k = 0; k < 12; k++) begin
      hist[k] = 16'($urandom);
      bus(1'b1, 1'b1, hist[k], 8'h0);
      rd(OFS_FH, w[15:8]);
      rd(OFS_FL, w[7:0]);
      if (k >= 8) chk(w, hist[k-8]);
    end
    // Event-only run stores eight data bytes on comparator B hits
    bval = 16'($urandom) | 16'h1;
    wr(OFS_CBH, bval[15:8]);
    wr(OFS_CBL, bval[7:0]);
    wr(OFS_TRIG, {4'h0, MODE_EV_B});
    wr(OFS_CTRL, 8'hc0);
    wr(OFS_CBH, ~bval[15:8]);
    rd(OFS_CBH, v);
    chk({8'h0, v}, {8'h0, bval[15:8]});
    rd(OFS_STAT, v);
    chk({8'h0, v}, 16'h20);
    for (int k = 0; k < 8; k++) begin
      ev[k] = 8'($urandom);
      bus(1'b0, 1'b0, bval, ev[k]);
      if (k == 3) rd(OFS_FL, v);
    end
    rd(OFS_STAT, v);
    chk({8'h0, v}, 16'h48);
    rd(OFS_FH, v);
    chk({8'h0, v}, 16'h0);
    for (int k = 0; k < 8; k++) begin
      rd(OFS_FL, v);
      chk({8'h0, v}, {8'h0, ev[k]});
    end
    rd(OFS_STAT, v);
    chk({8'h0, v}, 16'h48);
    // Comparator readback, direction qualification, break kinds
    aval = bval ^ 16'h8000;
    wr(OFS_CAH, aval[15:8]);
    wr(OFS_CAL, aval[7:0]);
    rd(OFS_CAH, w[15:8]);
    rd(OFS_CAL, w[7:0]);
    chk(w, aval);
    for (int j = 0; j < 8; j++) begin
      @(posedge clk) sel_b <= j[2];
      wr(OFS_TRIG, {7'h0, j[2]});
      c = j[2] ? {2'b11, j[1], 3'b100, j[0], 1'b1}
               : {2'b11, j[1], 1'b1, j[0], 3'b100};
      wr(OFS_CTRL, c);
      w = j[2] ? bval : aval;
      clear_seen();
      bus(~j[0], 1'b0, w, 8'h0);
      chk({15'h0, seen_m}, 16'h0);
      bus(j[0], 1'b0, w, 8'h0);
      chk({14'h0, seen_m, seen_brk}, 16'h3);
      chk({15'h0, seen_tag}, {15'h0, j[1]});
      rd(OFS_CTRL, v);
      chk({8'h0, v}, {8'h0, c & 8'hbf});
    end
    // Begin trace on A then B, select bit set; a full buffer ends the run
    wr(OFS_TRIG, 8'hc2);
    wr(OFS_CTRL, 8'hd0);
    clear_seen();
    bus(1'b0, 1'b0, aval, 8'h0);
    bus(1'b0, 1'b0, bval, 8'h0);
    for (int k = 0; k < 8; k++) begin
      hist[k] = 16'($urandom);
      bus(1'b1, 1'b1, hist[k], 8'h0);
    end
    chk({14'h0, seen_brk, seen_tag}, 16'h2);
    rd(OFS_STAT, v);
    chk({8'h0, v}, 16'hc8);
    for (int k = 0; k < 8; k++) begin
      rd(OFS_FH, w[15:8]);
      rd(OFS_FL, w[7:0]);
      chk(w, hist[k]);
    end
    finish_test();
  end
endmodule // tb
